// file: tpss_pkg.sv
// Package for the touch power state and status register bank.
// Assumes a byte-wide register port with 8-bit addresses.
package tpss_pkg;

  localparam logic [7:0] TPSS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TPSS_ADDR_GEN = 8'h02;
  localparam logic [7:0] TPSS_ADDR_INP = 8'h03;

  localparam logic [7:0] TPSS_CTRL_RESET = 8'h00;
  localparam logic [7:0] TPSS_GEN_RESET = 8'h00;
  localparam logic [7:0] TPSS_INP_RESET = 8'h00;

  localparam int TPSS_CTRL_GAIN_LSB = 6;
  localparam int TPSS_CTRL_STANDBY_ENABLE_BIT_BIT = 5;
  localparam int TPSS_CTRL_DSLP_BIT = 4;
  localparam int TPSS_CTRL_CGAIN_LSB = 2;
  localparam int TPSS_CTRL_COMBO_BIT = 1;
  localparam int TPSS_CTRL_INT_BIT = 0;

  localparam int TPSS_GEN_BASE_BIT = 6;
  localparam int TPSS_GEN_ACAL_BIT = 5;
  localparam int TPSS_GEN_PKEY_BIT = 4;
  localparam int TPSS_GEN_MANY_PRESS_BLOCK_FLAG_BIT = 2;
  localparam int TPSS_GEN_PATT_BIT = 1;
  localparam int TPSS_GEN_TOUCH_BIT = 0;

  localparam int TPSS_NUM_INPUTS = 6;

  typedef enum logic [3:0] {
    TPSS_PS_ACTIVE = 4'h1,
    TPSS_PS_STANDBY = 4'h2,
    TPSS_PS_COMBO = 4'h4,
    TPSS_PS_DEEP = 4'h8
  } tpss_pstate_e;

  typedef struct packed {
    logic [1:0] act_gain;
    logic standby_enable_bit;
    logic deep_sleep_enable_bit;
    logic [1:0] combo_gain;
    logic combo_en;
    logic int_pend;
  } tpss_ctrl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpss_req_s;

  typedef struct packed {
    logic [TPSS_NUM_INPUTS-1:0] input_touch;
    logic [TPSS_NUM_INPUTS-1:0] touch_irq_en;
    logic base_out;
    logic analog_cal_error_flag;
    logic power_held;
    logic many_press_block_flag_block;
    logic pattern_hit;
    logic pattern_irq_enable;
  } tpss_sense_s;

endpackage : tpss_pkg

// file: tpss_regs.sv
// Power state, gain and status register bank of a six-input touch unit.
// Assumes sense inputs are synchronous to clk_sys_i from the scan logic;
// register port is a single-cycle strobe port from the serial bus engine.
//
// Function
// (R1) Power state: deep sleep over combo over standby over active.
// (R2) Control register resets to zero; gains, enables, interrupt bit.
// (R3) Gain code 00,01,10,11 selects gain 1,2,4,8.
// (R4) Combo: active gain for active inputs, combo gain for standby inputs.
// (R5) Any gain change restarts calibration of all inputs from scratch.
// (R6) Standby scans standby inputs; status kept until cleared; dropped release.
// (R7) Combo scans both input sets; status kept; dropped inputs release.
// (R8) Entering deep sleep stops scanning, clears status and interrupt bit.
// (R9) Interrupt bit set holds active-low alert output asserted.
// (R10) Host writes 0 to clear interrupt; gone conditions clear too.
// (R11) Touch on interrupt-disabled input never sets interrupt bit.
// (R12) Two read-only status registers, reset zero, per-input bits 0..5.
// (R13) Base limit flag set while any enabled input out of limit.
// (R14) Calibration error flag set until all enabled inputs calibrate.
// (R15) Power key flag sets interrupt; clears on clear if released.
// (R16) Multi-touch block flag shows suppression, never sets interrupt.
// (R17) Pattern flag sets interrupt if enabled; clears when condition gone; here it stays set until a clear write finds it gone.
// (R18) Summary touch flag is OR of all per-input touch flags.
// (R19) Input flag clears on clear only if touch ended; no re-alert.
// (R20) Reset loads every register with its default.
// (R21) New touch on interrupt-enabled input sets the sticky interrupt bit.
`timescale 1ns/1ps
`default_nettype none

module tpss_regs #(
  parameter int NUM_INPUTS = 6
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire tpss_pkg::tpss_req_s req_i,
  input wire tpss_pkg::tpss_sense_s sense_i,
  input wire logic [NUM_INPUTS-1:0] active_inputs_i,
  input wire logic [NUM_INPUTS-1:0] standby_inputs_i,
  output logic [7:0] rdata_o,
  output logic nalert_o,
  output tpss_pkg::tpss_pstate_e pstate_o,
  output logic [NUM_INPUTS-1:0] scan_enable_o,
  output logic [NUM_INPUTS-1:0] input_gain_sel_o [2],
  output logic [3:0] active_gain_o,
  output logic [3:0] combo_gain_o,
  output logic recal_all_o
);
  import tpss_pkg::*;

  if (NUM_INPUTS != TPSS_NUM_INPUTS) begin : g_chk
    $error("tpss_regs: NUM_INPUTS must equal six");
  end

  // Read mux packs the input flags into one byte
  if (NUM_INPUTS > 8) begin : g_chk_width
    $error("tpss_regs: NUM_INPUTS must fit in a byte");
  end

  // Control byte is read back as the struct itself
  if ($bits(tpss_ctrl_s) != 8) begin : g_chk_ctrl
    $error("tpss_regs: control struct must be eight bits");
  end

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tpss_ctrl_s ctrl;
    logic [NUM_INPUTS-1:0] press;
    logic [NUM_INPUTS-1:0] press_seen;
    logic pkey;
    logic pkey_seen;
    logic patt;
    logic patt_seen;
    logic deep_prev;
    logic recal;
    logic [7:0] rdata;
  } tpss_state_s;

  tpss_state_s s_q;
  tpss_state_s s_d;

  //////////////////////////////////////////////////////////////////////////
  // Decode

  tpss_pstate_e pstate;
  logic [NUM_INPUTS-1:0] scanned;
  logic [NUM_INPUTS-1:0] touch_live;
  logic [7:0] gen_view;
  logic int_clear;
  logic ctrl_wr;
  logic deep_now;

  // Event edges, one per sticky flag
  logic [NUM_INPUTS-1:0] press_keep;
  logic [NUM_INPUTS-1:0] press_rise;
  logic pkey_rise;
  logic patt_rise;

  // Interrupt sources; the blocking flag is deliberately absent
  logic touch_irq;
  logic pkey_irq;
  logic patt_irq;

  // Register port decode
  logic [1:0] wr_gain;
  logic [1:0] wr_cgain;
  logic [7:0] rd_view;

  // 2^code gives 1,2,4,8
  function automatic logic [3:0] gain_of(input logic [1:0] code);
    gain_of = 4'h1 << code; // R3
  endfunction : gain_of

  always_comb begin
    if (s_q.ctrl.deep_sleep_enable_bit) begin
      pstate = TPSS_PS_DEEP; // R1
    end else if (s_q.ctrl.combo_en) begin
      pstate = TPSS_PS_COMBO; // R1
    end else if (s_q.ctrl.standby_enable_bit) begin
      pstate = TPSS_PS_STANDBY; // R1
    end else begin
      pstate = TPSS_PS_ACTIVE;
    end
    case (pstate)
      TPSS_PS_ACTIVE: begin
        scanned = active_inputs_i;
      end
      TPSS_PS_STANDBY: begin
        // Only the standby set stays awake
        scanned = standby_inputs_i; // R6
      end
      TPSS_PS_COMBO: begin
        scanned = active_inputs_i | standby_inputs_i; // R7
      end
      TPSS_PS_DEEP: begin
        // Nothing scanned; the sense logic may idle
        scanned = '0; // R8
      end
      default: begin
        scanned = '0;
      end
    endcase
  end

  // Unscanned inputs read as released, so their flags can drop
  assign touch_live = sense_i.input_touch & scanned; // R6 R7

  assign deep_now = (pstate == TPSS_PS_DEEP);

  //////////////////////////////////////////////////////////////////////////
  // Events

  // Per input: a clear keeps a held touch, drops a released one
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_press
    assign press_keep[i] = s_q.press[i] && touch_live[i]; // R19
    // Edge memory keeps a held touch from raising a second alert
    assign press_rise[i] = touch_live[i] && !s_q.press_seen[i]; // R19
  end

  // Level flags raise an event only on their rising edge
  assign pkey_rise = sense_i.power_held && !s_q.pkey_seen; // R15
  assign patt_rise = sense_i.pattern_hit && !s_q.patt_seen; // R17

  // Masked inputs and a disabled pattern alert stay silent
  assign touch_irq = |(press_rise & sense_i.touch_irq_en); // R11 R21
  assign pkey_irq = pkey_rise; // R15
  assign patt_irq = patt_rise && sense_i.pattern_irq_enable; // R17

  //////////////////////////////////////////////////////////////////////////
  // Register port decode

  // A write to any other address leaves the control byte alone

  assign ctrl_wr = req_i.wr && (req_i.addr == TPSS_ADDR_CTRL);
  assign int_clear = ctrl_wr && !req_i.wdata[TPSS_CTRL_INT_BIT]; // R10

  // Gain fields as written, compared against the held ones
  assign wr_gain = req_i.wdata[TPSS_CTRL_GAIN_LSB +: 2];
  assign wr_cgain = req_i.wdata[TPSS_CTRL_CGAIN_LSB +: 2];

  // Live levels are forced low asleep; sticky flags wait for a clear
  always_comb begin
    gen_view = TPSS_GEN_RESET;
    gen_view[TPSS_GEN_BASE_BIT] = sense_i.base_out && !deep_now; // R13
    gen_view[TPSS_GEN_ACAL_BIT] = sense_i.analog_cal_error_flag && !deep_now; // R14
    gen_view[TPSS_GEN_PKEY_BIT] = s_q.pkey; // R15
    gen_view[TPSS_GEN_MANY_PRESS_BLOCK_FLAG_BIT] = sense_i.many_press_block_flag_block && !deep_now; // R16
    gen_view[TPSS_GEN_PATT_BIT] = s_q.patt; // R17
    gen_view[TPSS_GEN_TOUCH_BIT] = |s_q.press; // R18
  end

  // Read mux: unmapped addresses read as zero
  always_comb begin
    case (req_i.addr)
      TPSS_ADDR_CTRL: begin
        rd_view = s_q.ctrl;
      end
      TPSS_ADDR_GEN: begin
        rd_view = gen_view; // R12
      end
      TPSS_ADDR_INP: begin
        // Upper bits of the byte have no input behind them
        rd_view = {{(8-NUM_INPUTS){1'b0}}, s_q.press}; // R12
      end
      default: begin
        rd_view = 8'h00;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [NUM_INPUTS-1:0] new_touch;
    logic new_pkey;
    logic new_patt;
    logic set_int;
    logic [1:0] gain_new;
    logic [1:0] cgain_new;
    new_touch = '0;
    new_pkey = 1'b0;
    new_patt = 1'b0;
    set_int = 1'b0;
    gain_new = s_q.ctrl.act_gain;
    cgain_new = s_q.ctrl.combo_gain;
    s_d = s_q;
    s_d.recal = 1'b0;
    s_d.deep_prev = (pstate == TPSS_PS_DEEP);

    // Status flags
    // Edge memories follow the live levels every cycle outside deep sleep
    new_touch = press_rise; // R19
    new_pkey = pkey_rise; // R15
    new_patt = patt_rise; // R17
    s_d.press_seen = touch_live;
    s_d.pkey_seen = sense_i.power_held;
    s_d.patt_seen = sense_i.pattern_hit;

    // Clear first, so a same-cycle event still wins
    if (int_clear) begin
      s_d.press = press_keep; // R10 R19
      s_d.pkey = s_q.pkey && sense_i.power_held; // R15
      s_d.patt = s_q.patt && sense_i.pattern_hit; // R17
    end
    s_d.press = s_d.press | new_touch;
    s_d.pkey = s_d.pkey | new_pkey;
    s_d.patt = s_d.patt | new_patt;


    // Interrupt bit
    set_int = touch_irq; // R11 R21
    set_int = set_int | pkey_irq; // R15
    set_int = set_int | patt_irq; // R17

    if (ctrl_wr) begin
      // Power state bits; priority is resolved in decode
      gain_new = wr_gain;
      cgain_new = wr_cgain;
      s_d.ctrl.act_gain = gain_new;
      s_d.ctrl.standby_enable_bit = req_i.wdata[TPSS_CTRL_STANDBY_ENABLE_BIT_BIT];
      s_d.ctrl.deep_sleep_enable_bit = req_i.wdata[TPSS_CTRL_DSLP_BIT];
      s_d.ctrl.combo_gain = cgain_new;
      s_d.ctrl.combo_en = req_i.wdata[TPSS_CTRL_COMBO_BIT];
      // Writing 1 leaves the bit alone; software cannot fake an alert
      if (!req_i.wdata[TPSS_CTRL_INT_BIT]) begin
        s_d.ctrl.int_pend = 1'b0; // R10
      end
    end
    if (set_int && pstate != TPSS_PS_DEEP) begin
      s_d.ctrl.int_pend = 1'b1; // R21
    end

    if (gain_new != s_q.ctrl.act_gain || cgain_new != s_q.ctrl.combo_gain) begin
      s_d.recal = 1'b1; // R5
    end

    // Deep sleep wipes all status and the pending interrupt
    if (pstate == TPSS_PS_DEEP) begin
      s_d.press = '0; // R8
      s_d.pkey = 1'b0; // R8
      s_d.patt = 1'b0; // R8
      s_d.ctrl.int_pend = 1'b0; // R8
      s_d.press_seen = '0;
      s_d.pkey_seen = 1'b0;
      s_d.patt_seen = 1'b0;
    end

    s_d.rdata = s_q.rdata;
    // Read data holds until the next read strobe
    if (req_i.rd) begin
      s_d.rdata = rd_view; // R12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      // Every field from a constant, so reset never depends on inputs
      s_q.ctrl <= TPSS_CTRL_RESET; // R2
      s_q.press <= TPSS_INP_RESET[NUM_INPUTS-1:0]; // R20
      s_q.press_seen <= '0;
      s_q.pkey <= TPSS_GEN_RESET[TPSS_GEN_PKEY_BIT]; // R20
      s_q.pkey_seen <= 1'b0;
      s_q.patt <= TPSS_GEN_RESET[TPSS_GEN_PATT_BIT]; // R20
      s_q.patt_seen <= 1'b0;
      s_q.deep_prev <= 1'b0;
      s_q.recal <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o = s_q.rdata;
  assign nalert_o = !s_q.ctrl.int_pend; // R9
  assign pstate_o = pstate;
  assign scan_enable_o = scanned;
  assign active_gain_o = gain_of(s_q.ctrl.act_gain);

  // Without combo every input runs at the active gain
  always_comb begin
    if (s_q.ctrl.combo_en) begin
      combo_gain_o = gain_of(s_q.ctrl.combo_gain); // R4
    end else begin
      combo_gain_o = gain_of(s_q.ctrl.act_gain); // R4
    end
  end
  assign recal_all_o = s_q.recal; // R5

  // Per input: index 1 means combo gain applies
  // Active-only inputs keep the active gain even in combo
  // Standby set follows the standby enables, not the scan mask
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_gain
    assign input_gain_sel_o[0][i] = !(s_q.ctrl.combo_en && standby_inputs_i[i]);
    assign input_gain_sel_o[1][i] = s_q.ctrl.combo_en && standby_inputs_i[i]; // R4
  end

endmodule : tpss_regs

`default_nettype wire

// file: tpss_host.sv
// Host model for the register strobe port.
// Assumes the bench calls xfer once per transfer.
`timescale 1ns/1ps
`default_nettype none
module tpss_host (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  output var tpss_pkg::tpss_req_s req_o
);
  import tpss_pkg::*;
  initial req_o = '{1'b0, 1'b0, 8'h55, 8'hAA};
  // Idle bus shows flipped values, never stale ones
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys_i);
    #1;
    req_o = '{w, !w, a, d};
    @(posedge clk_sys_i);
    #1;
    q = rdata_i;
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : xfer
endmodule : tpss_host
`default_nettype wire

// file: tpss_regs_asserts.sv
// Port checker for the register bank.
// Assumes bind onto tpss_regs.
`timescale 1ns/1ps
`default_nettype none
module tpss_regs_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire tpss_pkg::tpss_req_s req_i,
  input wire tpss_pkg::tpss_sense_s sense_i,
  input wire logic [5:0] standby_inputs_i,
  input wire logic [7:0] rdata_o,
  input wire logic nalert_o,
  input wire tpss_pkg::tpss_pstate_e pstate_o,
  input wire logic [5:0] scan_enable_o,
  input wire logic [3:0] active_gain_o,
  input wire logic recal_all_o
);
  import tpss_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic wc;
  assign wc = req_i.wr && req_i.addr == TPSS_ADDR_CTRL;
  function tpss_pstate_e ps(input logic [7:0] w);
    return w[4] ? TPSS_PS_DEEP : w[1] ? TPSS_PS_COMBO :
      w[5] ? TPSS_PS_STANDBY : TPSS_PS_ACTIVE;
  endfunction : ps
  chk_state_prio: assert property (
    wc |=> pstate_o == ps($past(req_i.wdata))) else $error("bad state");
  chk_gain_code: assert property (
    wc |=> active_gain_o == 4'h1 << $past(req_i.wdata[7:6]))
    else $error("bad gain");
  chk_gain_recal: assert property (
    $changed(active_gain_o) |-> recal_all_o) else $error("no recal");
  chk_int_clear: assert property (
    wc && !req_i.wdata[0] && sense_i.input_touch == 6'h00 &&
    !sense_i.power_held && !sense_i.pattern_hit |=> nalert_o)
    else $error("no clear");
  chk_deep_alert: assert property (
    pstate_o == TPSS_PS_DEEP |=> nalert_o) else $error("deep alert");
  chk_deep_scan: assert property (
    pstate_o == TPSS_PS_DEEP |-> scan_enable_o == 6'h00)
    else $error("deep scan");
  chk_standby_enable_bit_scan: assert property (
    pstate_o == TPSS_PS_STANDBY |-> scan_enable_o == standby_inputs_i)
    else $error("standby scan");
  chk_rd_unmap: assert property (
    req_i.rd && !(req_i.addr inside {8'h00, 8'h02, 8'h03})
    |=> rdata_o == 8'h00) else $error("unmapped read");
  chk_rd_hold: assert property (
    !req_i.rd |=> $stable(rdata_o)) else $error("read data moved");
endmodule : tpss_regs_chk
bind tpss_regs tpss_regs_chk tpss_regs_chk_inst (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .req_i(req_i), .sense_i(sense_i),
  .standby_inputs_i(standby_inputs_i),
  .rdata_o(rdata_o), .nalert_o(nalert_o), .pstate_o(pstate_o),
  .scan_enable_o(scan_enable_o), .active_gain_o(active_gain_o),
  .recal_all_o(recal_all_o));
`default_nettype wire

// file: tpss_regs_tb.sv
// Self-checking bench for the register bank.
// Assumes tpss_host drives the strobe port.
`timescale 1ns/1ps
`default_nettype none
module tpss_regs_tb;
  import tpss_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  tpss_req_s req;
  tpss_sense_s sense = '0;
  logic [5:0] act = 6'h3F;
  logic [5:0] stb = 6'h05;
  logic [7:0] rdata, q;
  logic nalert, recal;
  tpss_pstate_e pstate;
  logic [5:0] scan;
  logic [5:0] gsel [2];
  logic [3:0] again, cgain;
  int n_mismatch = 0;
  int samples_checked = 0;
  tpss_regs tpss_regs_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .req_i(req), .sense_i(sense), .active_inputs_i(act),
    .standby_inputs_i(stb), .rdata_o(rdata), .nalert_o(nalert),
    .pstate_o(pstate), .scan_enable_o(scan), .input_gain_sel_o(gsel),
    .active_gain_o(again), .combo_gain_o(cgain), .recal_all_o(recal));
  tpss_host tpss_host_inst (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
    .req_o(req));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////
  task cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task cka(input logic e);
    cmp({7'h0, nalert}, {7'h0, e});
  endtask : cka
  task wr(input logic [7:0] a, input logic [7:0] d);
    tpss_host_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    tpss_host_inst.xfer(1'b0, a, 8'h00, q);
    cmp(q, e);
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wt
  task t_reset;
    rd(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_GEN, 8'h00);
    rd(TPSS_ADDR_INP, 8'h00);
    rd(8'h07, 8'h00);
    wr(TPSS_ADDR_CTRL, 8'h01);
    wt(2);
    cka(1'b1);
  endtask : t_reset
  task t_state;
    logic [7:0] w [4] = '{8'h20, 8'h22, 8'h32, 8'h00};
    logic [3:0] e [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
    logic [5:0] sc [4] = '{6'h05, 6'h3F, 6'h00, 6'h3F};
    for (int i = 0; i < 4; i++) begin
      wr(TPSS_ADDR_CTRL, w[i]);
      cmp({4'h0, pstate}, {4'h0, e[i]});
      cmp({2'b0, scan}, {2'b0, sc[i]});
      rd(TPSS_ADDR_CTRL, w[i]);
    end
  endtask : t_state
  task t_gain;
    for (int i = 3; i >= 0; i--) begin
      wr(TPSS_ADDR_CTRL, 8'(i << 6));
      cmp({4'h0, again}, 8'h01 << i);
      cmp({4'h0, cgain}, 8'h01 << i);
      cmp({7'h0, recal}, 8'h01);
    end
    wr(TPSS_ADDR_CTRL, 8'h4E);
    cmp({again, cgain}, 8'h28);
    cmp({2'b0, gsel[1]}, {2'b0, stb});
    cmp({2'b0, gsel[0]}, {2'b0, ~stb});
    wr(TPSS_ADDR_CTRL, 8'h00);
    wr(TPSS_ADDR_CTRL, 8'h00);
    cmp({7'h0, recal}, 8'h00);
  endtask : t_gain
  task t_touch;
    sense.touch_irq_en = 6'h3F;
    sense.input_touch = 6'h04;
    wt(3);
    cka(1'b0);
    rd(TPSS_ADDR_INP, 8'h04);
    rd(TPSS_ADDR_GEN, 8'h01);
    wr(TPSS_ADDR_CTRL, 8'h00);
    wt(3);
    cka(1'b1);
    rd(TPSS_ADDR_INP, 8'h04);
    sense.input_touch = 6'h00;
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_INP, 8'h00);
  endtask : t_touch
  task t_flags;
    sense = '{input_touch: 6'h01, touch_irq_en: 6'h3E, default: '0};
    wt(3);
    cka(1'b1);
    sense = '0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    sense = '{base_out: 1'b1, analog_cal_error_flag: 1'b1, many_press_block_flag_block: 1'b1,
      default: '0};
    wt(3);
    cka(1'b1);
    rd(TPSS_ADDR_GEN, 8'h64);
    sense = '{pattern_hit: 1'b1, default: '0};
    wt(3);
    cka(1'b1);
    sense = '0;
    wt(1);
    sense = '{pattern_hit: 1'b1, pattern_irq_enable: 1'b1, default: '0};
    wt(3);
    cka(1'b0);
    rd(TPSS_ADDR_GEN, 8'h02);
    sense = '0;
    wr(TPSS_ADDR_CTRL, 8'h00);
    sense.power_held = 1'b1;
    wt(3);
    rd(TPSS_ADDR_GEN, 8'h10);
    cka(1'b0);
    wr(TPSS_ADDR_CTRL, 8'h00);
    rd(TPSS_ADDR_GEN, 8'h10);
    cka(1'b1);
    sense.power_held = 1'b0;
    wt(1);
    sense.power_held = 1'b1;
    wt(2);
    wr(TPSS_ADDR_CTRL, 8'h11);
    cka(1'b0);
    wt(2);
    cka(1'b1);
    rd(TPSS_ADDR_GEN, 8'h00);
  endtask : t_flags
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    wt(8);
    nrst_i = 1'b1;
    t_reset();
    t_state();
    t_gain();
    t_touch();
    t_flags();
    end_sim();
  end
  // Run needs about 110 cycles; generous margin
  initial begin
    #1ms;
    n_mismatch++;
    end_sim();
  end
endmodule : tpss_regs_tb
`default_nettype wire
